// ==== verilog/tws_pkg.sv ====
/*
 * Shared constants and types for the two-wire configuration link:
 * bus timing, slave address codes, access modes and host operations.
 * Assumes the host end runs on a 50 ns clock; the device end samples
 * the wires on its own link clock and needs no timing figures.
 */
package tws_pkg;

    // host clock period and the bus timing minimums, in ns
    localparam int CLK_NS = 50;
    localparam int T_LOW_NS = 4700;
    localparam int T_HIGH_NS = 4000;
    localparam int T_BUF_NS = 4700;
    localparam int T_SU_STA_NS = 4700;
    localparam int T_HD_STA_NS = 4000;
    localparam int T_SU_STO_NS = 4700;

    // least times round up to whole cycles
    localparam int LOW_I = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int HIGH_I = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] LOW_CYC = 8'(LOW_I);
    localparam logic [7:0] HIGH_CYC = 8'(HIGH_I);
    localparam logic [7:0] HALF_LOW_CYC = 8'(LOW_I / 2);
    localparam logic [7:0] HALF_HIGH_CYC = 8'(HIGH_I / 2);
    localparam logic [7:0] BUF_CYC = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SU_STA_CYC =
        8'((T_SU_STA_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HD_STA_CYC =
        8'((T_HD_STA_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SU_STO_CYC =
        8'((T_SU_STO_NS + CLK_NS - 1) / CLK_NS);

    // device-type codes; both values are arbitrary
    localparam logic [3:0] TYPE_CODE_A = 4'h6;
    localparam logic [3:0] TYPE_CODE_B = 4'h7;

    // register access rights; 2'b1x means the port is shut
    localparam logic [1:0] ACC_RW = 2'h0;
    localparam logic [1:0] ACC_RO = 2'h1;

    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    localparam logic SYNC_RST = 1'b1; // wires rest released

    typedef enum logic [1:0] {
        TWS_OP_START,
        TWS_OP_WRITE,
        TWS_OP_READ,
        TWS_OP_STOP
    } tws_op_t;

endpackage

// ==== verilog/tws_if.sv ====
/*
 * Wire-level meeting point of the host end and the device end.
 * Assumes both ends drive only low (open drain); released wires
 * read high through the implied pull-ups.
 */
`timescale 1ns/1ps
interface tws_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and of every enabled driver
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (
        input scl,
        input sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface

// ==== verilog/tws_sync.sv ====
/*
 * Two-flop synchroniser for a bundle of unrelated levels.
 * Assumes each bit is a slow level; no bit pairs with another.
 */
`timescale 1ns/1ps
module tws_sync import tws_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tws_sync_t;

    tws_sync_t s_q, s_d;

    // first stage feeds only the second
    always_comb begin
        s_d = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= {{W{SYNC_RST}}, {W{SYNC_RST}}};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule // tws_sync

// ==== verilog/tws_dev_end.sv ====
/*
 * Device end of the two-wire configuration link: a slave that holds a
 * sixteen-byte register array, answers address, word-address, write
 * and read bytes, and pulses nv_write_start when a write ends in stop.
 * Assumes link_clk oversamples the bus wires many times per bit and
 * srst is synchronous to link_clk. The user port shares link_clk.
 */
`timescale 1ns/1ps
module tws_dev_end import tws_pkg::*; (
    input wire logic link_clk,
    input wire logic srst,
    tws_if.dev bus,
    input wire logic addr_select_pin_hi,
    input wire logic addr_select_pin_mid,
    input wire logic addr_select_pin_lo,
    input wire logic type_sel,
    input wire logic [1:0] access_sel,
    input wire logic match_en,
    input wire logic [3:0] user_addr,
    output logic [7:0] user_rdata,
    output logic nv_write_start,
    output logic busy
);
    typedef enum logic [2:0] {
        DS_IDLE,
        DS_RX,
        DS_RX_ACK,
        DS_TX,
        DS_TX_ACK,
        DS_IGNORE
    } tws_dstate_t;

    typedef enum logic [1:0] {
        DK_ADDR,
        DK_WORD,
        DK_DATA
    } tws_kind_t;

    typedef struct packed {
        tws_dstate_t st;
        tws_kind_t kind;
        logic scl_p;
        logic sda_p;
        logic [7:0] sh;
        logic [3:0] bitn;
        logic rw;
        logic [3:0] ptr;
        logic [2:0] strap;
        logic wrote;
        logic sda_o;
        logic sda_oe;
        logic nv;
        logic busy;
        logic [7:0] rdata;
        logic [15:0][7:0] mem;
    } tws_dev_t;

    tws_dev_t s_q, s_d;
    logic [4:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    logic [3:0] type_code;
    logic addr_hit;

    // wires and straps all come from outside this clock
    tws_sync #(.W(5)) u_sync (
        .clk(link_clk),
        .srst(srst),
        .d({bus.scl, bus.sda, addr_select_pin_hi, addr_select_pin_mid,
            addr_select_pin_lo}),
        .q(sync_q)
    );

    assign scl_s = sync_q[4];
    assign sda_s = sync_q[3];

    // bus conditions from synced wires and their last values
    assign start_ev = s_q.scl_p & scl_s & s_q.sda_p & ~sda_s;
    assign stop_ev = s_q.scl_p & scl_s & ~s_q.sda_p & sda_s;
    assign scl_rise = ~s_q.scl_p & scl_s;
    assign scl_fall = s_q.scl_p & ~scl_s;

    // address decode on the byte just shifted in
    assign type_code = type_sel ? TYPE_CODE_B : TYPE_CODE_A;
    assign addr_hit = (s_q.sh[7:4] == type_code)
        & (~match_en | (s_q.sh[3:1] == s_q.strap))
        & ~access_sel[1];

    // one step of the slave; start and stop outrank all else
    always_comb begin
        s_d = s_q;
        s_d.scl_p = scl_s;
        s_d.sda_p = sda_s;
        s_d.nv = 1'b0;
        s_d.rdata = s_q.mem[user_addr];
        if (s_q.st == DS_IDLE) begin
            s_d.strap = sync_q[2:0]; // straps only move while idle
        end
        if (start_ev) begin
            s_d.st = DS_RX;
            s_d.kind = DK_ADDR;
            s_d.bitn = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop_ev) begin
            s_d.st = DS_IDLE;
            s_d.sda_oe = 1'b0;
            s_d.nv = s_q.wrote;
            s_d.wrote = 1'b0;
        end else begin
            case (s_q.st)
                DS_RX: begin
                    if (scl_rise && s_q.bitn != BYTE_BITS) begin
                        s_d.sh = {s_q.sh[6:0], sda_s};
                        s_d.bitn = s_q.bitn + 4'h1;
                    end else if (scl_fall && s_q.bitn == BYTE_BITS) begin
                        s_d.bitn = 4'h0;
                        s_d.st = DS_RX_ACK;
                        s_d.sda_oe = 1'b1;
                        case (s_q.kind)
                            DK_ADDR: begin
                                s_d.rw = s_q.sh[0];
                                if (!addr_hit) begin
                                    s_d.st = DS_IGNORE;
                                    s_d.sda_oe = 1'b0;
                                end
                            end
                            DK_WORD: begin
                                s_d.ptr = s_q.sh[3:0];
                            end
                            default: begin
                                if (access_sel == ACC_RW) begin
                                    s_d.mem[s_q.ptr] = s_q.sh;
                                    s_d.ptr = s_q.ptr + 4'h1;
                                    s_d.wrote = 1'b1;
                                end else begin
                                    // read-only: byte refused, no ack
                                    s_d.st = DS_IGNORE;
                                    s_d.sda_oe = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                DS_RX_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        if (s_q.kind == DK_ADDR && s_q.rw == RW_READ) begin
                            s_d.st = DS_TX;
                            s_d.sh = s_q.mem[s_q.ptr];
                            s_d.sda_oe = ~s_q.mem[s_q.ptr][7];
                            s_d.bitn = 4'h0;
                        end else begin
                            s_d.st = DS_RX;
                            s_d.kind = (s_q.kind == DK_ADDR) ? DK_WORD
                                                             : DK_DATA;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (s_q.bitn == TX_LAST_BIT) begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = DS_TX_ACK;
                        end else begin
                            s_d.sh = {s_q.sh[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.sh[6];
                            s_d.bitn = s_q.bitn + 4'h1;
                        end
                    end
                end
                DS_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            s_d.st = DS_IGNORE;
                        end else begin
                            s_d.ptr = s_q.ptr + 4'h1;
                            s_d.bitn = 4'h0;
                        end
                    end else if (scl_fall && s_q.bitn == 4'h0) begin
                        s_d.st = DS_TX;
                        s_d.sh = s_q.mem[s_q.ptr];
                        s_d.sda_oe = ~s_q.mem[s_q.ptr][7];
                    end
                end
                DS_IDLE, DS_IGNORE: begin
                    s_d.sda_oe = 1'b0;
                end
                default: begin
                    s_d.st = DS_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
        s_d.busy = (s_d.st != DS_IDLE);
    end

    // register array clears with the rest of the state
    always_ff @(posedge link_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.dev_sda_o = s_q.sda_o;
    assign bus.dev_sda_oe = s_q.sda_oe;
    assign user_rdata = s_q.rdata;
    assign nv_write_start = s_q.nv;
    assign busy = s_q.busy;
endmodule // tws_dev_end

// ==== verilog/tws_host_end.sv ====
/*
 * Host end of the two-wire configuration link: a byte-level master
 * that makes the bus clock from clk by counting and runs one
 * operation (start, write byte, read byte, stop) per request.
 * Assumes the device never stretches the clock.
 */
`timescale 1ns/1ps
module tws_host_end import tws_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    tws_if.host bus,
    input wire logic op_valid,
    input wire tws_op_t op_code,
    input wire logic [7:0] op_data,
    input wire logic op_nack,
    output logic op_ready,
    output logic res_valid,
    output logic [7:0] res_data,
    output logic res_ack
);
    typedef enum logic [3:0] {
        HS_IDLE,
        HS_WAIT,
        HS_STA_HI,
        HS_STA_HOLD,
        HS_RS_LO,
        HS_BIT_LO,
        HS_BIT_HI,
        HS_STO_LO,
        HS_STO_HI,
        HS_STO_BUF
    } tws_hstate_t;

    typedef struct packed {
        tws_hstate_t st;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
        logic ready;
        logic rv;
        logic [7:0] rdata;
        logic rack;
    } tws_host_t;

    tws_host_t s_q, s_d;
    logic sda_s;
    logic take;

    // the data wire also carries the device's drive
    tws_sync #(.W(1)) u_sync (
        .clk(clk),
        .srst(srst),
        .d(bus.sda),
        .q(sda_s)
    );

    assign take = op_valid & s_q.ready;

    // bit timing: data moves at mid-low, sampled at mid-high
    always_comb begin
        s_d = s_q;
        s_d.cnt = s_q.cnt + 8'h01;
        s_d.rv = 1'b0;
        case (s_q.st)
            HS_IDLE: begin
                s_d.scl_oe = 1'b0;
                s_d.sda_oe = 1'b0;
                s_d.ready = ~take;
                s_d.cnt = 8'h00;
                if (take && op_code == TWS_OP_START) begin
                    s_d.st = HS_STA_HI;
                end else if (take) begin
                    s_d.rv = 1'b1; // refused: no transfer open
                    s_d.rack = 1'b0;
                end
            end
            HS_WAIT: begin
                s_d.ready = ~take;
                s_d.cnt = 8'h00;
                s_d.bitn = 4'h0;
                if (take) begin
                    case (op_code)
                        TWS_OP_START: s_d.st = HS_RS_LO;
                        TWS_OP_WRITE: begin
                            s_d.sh = {op_data, 1'b1};
                            s_d.st = HS_BIT_LO;
                        end
                        TWS_OP_READ: begin
                            s_d.sh = {8'hFF, op_nack};
                            s_d.st = HS_BIT_LO;
                        end
                        default: s_d.st = HS_STO_LO;
                    endcase
                end
            end
            HS_STA_HI: begin
                if (s_q.cnt == SU_STA_CYC) begin
                    s_d.sda_oe = 1'b1;
                    s_d.st = HS_STA_HOLD;
                    s_d.cnt = 8'h00;
                end
            end
            HS_STA_HOLD: begin
                if (s_q.cnt == HD_STA_CYC) begin
                    s_d.scl_oe = 1'b1;
                    s_d.st = HS_WAIT;
                    s_d.rv = 1'b1;
                    s_d.rack = 1'b1;
                end
            end
            HS_RS_LO, HS_BIT_LO, HS_STO_LO: begin
                if (s_q.cnt == HALF_LOW_CYC) begin
                    s_d.sda_oe = (s_q.st == HS_BIT_LO) ? ~s_q.sh[8]
                               : (s_q.st == HS_STO_LO);
                end
                if (s_q.cnt == LOW_CYC) begin
                    s_d.scl_oe = 1'b0;
                    s_d.cnt = 8'h00;
                    s_d.st = (s_q.st == HS_RS_LO) ? HS_STA_HI
                           : (s_q.st == HS_BIT_LO) ? HS_BIT_HI : HS_STO_HI;
                end
            end
            HS_BIT_HI: begin
                if (s_q.cnt == HALF_HIGH_CYC) begin
                    s_d.sh = {s_q.sh[7:0], sda_s};
                end
                if (s_q.cnt == HIGH_CYC) begin
                    s_d.scl_oe = 1'b1;
                    s_d.cnt = 8'h00;
                    if (s_q.bitn == BYTE_BITS) begin
                        s_d.st = HS_WAIT;
                        s_d.rv = 1'b1;
                        s_d.rdata = s_q.sh[8:1];
                        s_d.rack = ~s_q.sh[0];
                    end else begin
                        s_d.bitn = s_q.bitn + 4'h1;
                        s_d.st = HS_BIT_LO;
                    end
                end
            end
            HS_STO_HI: begin
                if (s_q.cnt == SU_STO_CYC) begin
                    s_d.sda_oe = 1'b0;
                    s_d.st = HS_STO_BUF;
                    s_d.cnt = 8'h00;
                end
            end
            HS_STO_BUF: begin
                if (s_q.cnt == BUF_CYC) begin
                    s_d.st = HS_IDLE;
                    s_d.rv = 1'b1;
                    s_d.rack = 1'b1;
                end
            end
            default: s_d.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.host_scl_o = s_q.scl_o;
    assign bus.host_scl_oe = s_q.scl_oe;
    assign bus.host_sda_o = s_q.sda_o;
    assign bus.host_sda_oe = s_q.sda_oe;
    assign op_ready = s_q.ready;
    assign res_valid = s_q.rv;
    assign res_data = s_q.rdata;
    assign res_ack = s_q.rack;
endmodule // tws_host_end

// ==== bench/tws_sva.sv ====
/*
 * Wire checker for the two-wire link: reset release, open-drain use,
 * clock phase lengths, start hold and bus free time after stop.
 * Assumes the bench hands in both clocks, the shared srst and every
 * signal of the interface that joins the two ends.
 */
`timescale 1ns/1ps
module tws_sva_chk import tws_pkg::*; (
    input wire logic clk,
    input wire logic link_clk,
    input wire logic srst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] hi_q;
    logic [7:0] lo_q;

    // run lengths of the clock wire; saturate so idle cannot wrap
    always_ff @(posedge clk) begin
        if (srst) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_q <= scl ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
            lo_q <= !scl ? lo_q + {7'h00, lo_q != 8'hFF} : 8'h00;
        end
    end

    a_rst_host: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> !host_scl_oe && !host_sda_oe)
        else $error("host holds a wire after reset");
    a_rst_dev: assert property (@(posedge link_clk) disable iff (srst)
        $fell(srst) |-> !dev_sda_oe)
        else $error("device holds data after reset");
    a_open_drain: assert property (@(posedge clk) disable iff (srst)
        !(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o)
        && !(dev_sda_oe && dev_sda_o))
        else $error("a wire is driven high");
    a_dev_low_edge: assert property (@(posedge link_clk)
        disable iff (srst) $changed(dev_sda_oe) |-> !scl)
        else $error("device moved data while clock high");
    a_scl_high_min: assert property (@(posedge clk) disable iff (srst)
        $fell(scl) |-> hi_q >= HIGH_CYC - 8'h01)
        else $error("clock high phase too short");
    a_scl_low_min: assert property (@(posedge clk) disable iff (srst)
        $rose(scl) |-> lo_q >= LOW_CYC - 8'h01)
        else $error("clock low phase too short");
    a_start_hold: assert property (@(posedge clk) disable iff (srst)
        $fell(sda) && scl |=> scl [*8])
        else $error("clock fell right after start");
    a_stop_free: assert property (@(posedge clk) disable iff (srst)
        $rose(sda) && scl |=> (scl && sda) [*8])
        else $error("bus not left free after stop");
endmodule // tws_sva_chk

// ==== bench/test_two_wire_config_slave.sv ====
/*
 * Self-checking bench: host end and device end joined by the link
 * interface, host ops driven at the falling clk edge, results checked
 * from a queue of notes. Assumes package, interface and ends compile
 * first; the link clock is made here, unrelated in phase.
 */
`timescale 1ns/1ps
module test_two_wire_config_slave import tws_pkg::*;;
    localparam logic [1:0] CA = 2'h1; // compare ack only
    localparam logic [1:0] CD = 2'h2; // compare data only
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic op_valid, op_nack, op_ready, res_valid, res_ack, busy;
    logic type_sel, match_en, nv_write_start;
    tws_op_t op_code;
    logic [7:0] op_data, res_data, user_rdata, d;
    logic [1:0] access_sel;
    logic [3:0] user_addr;
    logic [2:0] strap, s;
    logic [10:0] nt;
    logic [10:0] expq[$];
    logic [7:0] mem[16];
    int fails = 0;
    int tests_run = 0;
    int seed = 10216;
    int nv_cnt = 0;
    int nv0, i, k;

    tws_if bus ();
    tws_host_end u_tws_host_end (.clk(clk), .srst(srst), .bus(bus),
        .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
        .op_nack(op_nack), .op_ready(op_ready), .res_valid(res_valid),
        .res_data(res_data), .res_ack(res_ack));
    tws_dev_end u_tws_dev_end (.link_clk(link_clk), .srst(srst),
        .bus(bus), .addr_select_pin_hi(strap[2]),
        .addr_select_pin_mid(strap[1]), .addr_select_pin_lo(strap[0]),
        .type_sel(type_sel), .access_sel(access_sel),
        .match_en(match_en), .user_addr(user_addr),
        .user_rdata(user_rdata), .nv_write_start(nv_write_start),
        .busy(busy));
    tws_sva_chk u_tws_sva_chk (.clk(clk), .link_clk(link_clk),
        .srst(srst), .host_scl_o(bus.host_scl_o),
        .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
        .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
        .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));

    // two unrelated clocks
    initial forever #25 clk = ~clk;
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // bounded wait for the host; a byte takes about 1600 cycles
    task automatic wait_ready();
        int w;
        w = 0;
        while (op_ready !== 1'b1 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        chk({7'h00, op_ready}, 8'h01);
    endtask

    // one host op; note first, then hold valid for the taking edge
    task automatic op(input tws_op_t c, input logic [1:0] m,
        input logic a, input logic [7:0] dd = 8'h00,
        input logic [7:0] e = 8'h00, input logic n = 1'b0);
        wait_ready();
        expq.push_back({m, a, e});
        op_code = c;
        op_data = dd;
        op_nack = n;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        @(negedge clk);
    endtask

    // bus must rest released and device idle after each test
    task automatic done(input string t);
        wait_ready(); // stop op only ends once the bus is free
        repeat (8) @(negedge clk);
        chk({5'h00, bus.scl, bus.sda, busy}, 8'h06);
        $display("test %s ended, mismatches %0d", t, fails);
    endtask

    function automatic logic [7:0] ab(input logic [3:0] t,
        input logic [2:0] sel, input logic rw);
        return {t, sel, rw};
    endfunction

    // results compared against the oldest note
    always @(negedge clk) begin
        if (res_valid === 1'b1) begin
            nt = (expq.size() > 0) ? expq.pop_front() : 11'h7FF;
            if (nt[10]) chk(res_data, nt[7:0]);
            if (nt[9]) chk({7'h00, res_ack}, {7'h00, nt[8]});
        end
    end

    // count programming launches; one cycle each, read mid-cycle
    always @(negedge link_clk) begin
        if (nv_write_start === 1'b1) nv_cnt++;
    end

    // hang guard, well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        $display("[FAIL] %0t watchdog expired", $time);
        fails++;
        give_verdict();
    end

    initial begin
        op_valid = 1'b0;
        op_code = TWS_OP_START;
        op_data = 8'h00;
        op_nack = 1'b0;
        type_sel = 1'b0;
        access_sel = ACC_RW;
        match_en = 1'b1;
        user_addr = 4'h0;
        strap = 3'($random(seed));
        for (i = 0; i < 16; i++) mem[i] = 8'h00;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        op(TWS_OP_WRITE, CA, 1'b0);
        done("idle refusal");
        // write that wraps the counter, then launches programming
        nv0 = nv_cnt;
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b1, ab(TYPE_CODE_A, strap, 1'b0));
        op(TWS_OP_WRITE, CA, 1'b1, 8'h0E);
        for (i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            mem[4'(14 + i)] = d;
            op(TWS_OP_WRITE, 2'h3, 1'b1, d, d);
        end
        op(TWS_OP_STOP, CA, 1'b1);
        done("write with wrap");
        chk(8'(nv_cnt - nv0), 8'h01);
        for (i = 0; i < 16; i++) begin
            user_addr = 4'(i);
            repeat (2) @(negedge clk);
            chk(user_rdata, mem[i]);
        end
        // random read running sequentially over the top address
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b1, ab(TYPE_CODE_A, strap, 1'b0));
        op(TWS_OP_WRITE, CA, 1'b1, 8'h0F);
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b1, ab(TYPE_CODE_A, strap, 1'b1));
        op(TWS_OP_READ, CD, 1'b0, 8'h00, mem[15]);
        op(TWS_OP_READ, CD, 1'b0, 8'h00, mem[0]);
        op(TWS_OP_READ, CD, 1'b0, 8'h00, mem[1], 1'b1);
        op(TWS_OP_STOP, CA, 1'b1);
        done("sequential read");
        // nacked byte must not move the counter
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b1, ab(TYPE_CODE_A, strap, 1'b1));
        op(TWS_OP_READ, CD, 1'b0, 8'h00, mem[1], 1'b1);
        op(TWS_OP_STOP, CA, 1'b1);
        done("current read");
        // foreign type code: silent until the next start
        nv0 = nv_cnt;
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b0, ab(TYPE_CODE_B, strap, 1'b0));
        op(TWS_OP_WRITE, CA, 1'b0, 8'h00);
        op(TWS_OP_STOP, CA, 1'b1);
        done("foreign type");
        chk(8'(nv_cnt - nv0), 8'h00);
        // second type code, pin match on and off, port shut
        for (k = 0; k < 5; k++) begin
            type_sel = 1'b1;
            match_en = (k != 2);
            access_sel = (k > 2) ? 2'(k - 1) : ACC_RW;
            s = (k == 0 || k > 2) ? strap : ~strap;
            repeat (4) @(negedge clk);
            op(TWS_OP_START, CA, 1'b1);
            op(TWS_OP_WRITE, CA, k != 1 && k < 3,
                ab(TYPE_CODE_B, s, 1'b0));
            op(TWS_OP_STOP, CA, 1'b1);
            done("address options");
        end
        // read only: data byte refused and not stored
        type_sel = 1'b0;
        match_en = 1'b1;
        access_sel = ACC_RO;
        repeat (4) @(negedge clk);
        op(TWS_OP_START, CA, 1'b1);
        op(TWS_OP_WRITE, CA, 1'b1, ab(TYPE_CODE_A, strap, 1'b0));
        op(TWS_OP_WRITE, 2'h0, 1'b0, 8'h02);
        op(TWS_OP_WRITE, CA, 1'b0, ~mem[2]);
        op(TWS_OP_STOP, CA, 1'b1);
        done("read only");
        user_addr = 4'h2;
        repeat (2) @(negedge clk);
        chk(user_rdata, mem[2]);
        chk(8'(expq.size()), 8'h00);
        give_verdict();
    end
endmodule // test_two_wire_config_slave
